// ---- hw/uotg_cfg.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "uotg_params.svh"
module uotg_cfg
  import uotg_pkg::*;
#(
  parameter int FRAME_CYCLES = `UOTG_FRAME_CYCLES
)(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Serial engine side
  input  wire logic        line_drive,
  input  wire logic        token_done,
  input  wire logic        sys_idle,
  output logic             token_start,
  output logic      [3:0]  token_kind,
  output logic      [3:0]  target_endpoint,
  output logic      [6:0]  token_device,
  output logic             frame_marker,
  output logic             low_speed_mode,
  output logic             module_run,
  // Configuration outputs
  output logic             eye_test_enable,
  output logic             drive_oe_n,
  output logic      [15:0] pp_out_mask,
  output logic      [15:0] pp_in_mask,
  output logic             bus_power_pullup_enable,
  output logic             external_serial_ctrl_select,
  output logic             boost_builder_enable,
  output logic             digital_vbus_ctrl_enable,
  output logic             bus_comparator_enable,
  output logic             digital_vbus_status_enable,
  output logic             transceiver_enable,
  output logic             external_xcvr_enable
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic       rst_meta_q;
  logic       rst_n_q;
  // Release is synchronised so no flop leaves reset a cycle apart
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // Ping-pong decode
  // ---------------------------------------------------------------
  function automatic logic uotg_pp_on(input logic [1:0] cfg, input int endp, input logic is_out);
    unique case (cfg)
      2'b11:   uotg_pp_on = (endp != 0);
      2'b10:   uotg_pp_on = 1'b1;
      2'b01:   uotg_pp_on = (endp == 0) && is_out;
      2'b00:   uotg_pp_on = 1'b0;
    endcase
  endfunction : uotg_pp_on

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  logic [7:0] addr_q;
  logic [7:0] token_q;
  logic [7:0] thresh_q;
  logic [7:0] cfg1_q;
  logic [7:0] cfg2_q;
  logic [7:0] power_q;
  logic       ack_q;
  logic [31:0] rdat_q;
  logic       req;
  logic       wr_en;
  logic [7:0] wbyte;
  logic [7:0] status;
  logic       host_mode;
  logic       tok_write;
  uotg_tok_state_type state_q;
  logic       window_ok;

  assign req       = wb_cyc_i && wb_stb_i;
  // Write commits at the acknowledging edge, only on lane 0
  assign wr_en     = req && wb_we_i && ack_q && wb_sel_i[0];
  assign wbyte     = wb_dat_i[7:0];
  assign host_mode = power_q[`UOTG_BIT_HOST];
  assign tok_write = wr_en && (wb_adr_i == `UOTG_OFS_TOKEN);
  assign wb_ack_o  = ack_q;
  assign wb_dat_o  = rdat_q;
  assign status    = {4'h0, module_run, window_ok, state_q == UOTG_WAIT, state_q == UOTG_BUSY};

  // One-cycle ack, dropped in the cycle after it is given
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      ack_q <= 1'b0;
    else
      ack_q <= req && !ack_q;
  end

  // Read mux; unmapped offsets answer zero
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      rdat_q <= 32'h0000_0000;
    else if (req && !ack_q)
    begin
      unique case (wb_adr_i)
        `UOTG_OFS_ADDR:   rdat_q <= {24'h0, addr_q[7] && host_mode, addr_q[6:0]};
        `UOTG_OFS_TOKEN:  rdat_q <= {24'h0, token_q};
        `UOTG_OFS_THRESH: rdat_q <= {24'h0, thresh_q};
        `UOTG_OFS_CFG1:   rdat_q <= {24'h0, cfg1_q};
        `UOTG_OFS_CFG2:   rdat_q <= {24'h0, cfg2_q};
        `UOTG_OFS_POWER:  rdat_q <= {24'h0, power_q};
        `UOTG_OFS_STATUS: rdat_q <= {24'h0, status};
        default:          rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  // Device number; low-speed bit only kept in host mode
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      addr_q <= `UOTG_RESET_BYTE;
    else if (wr_en && wb_adr_i == `UOTG_OFS_ADDR)
      addr_q <= {wbyte[7] && host_mode, wbyte[6:0]};
  end

  // Token, threshold and configuration storage
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      token_q  <= `UOTG_RESET_BYTE;
      thresh_q <= `UOTG_RESET_BYTE;
      cfg1_q   <= `UOTG_RESET_BYTE;
      cfg2_q   <= `UOTG_RESET_BYTE;
      power_q  <= `UOTG_RESET_BYTE;
    end
    else if (wr_en)
    begin
      unique case (wb_adr_i)
        `UOTG_OFS_TOKEN:  token_q  <= wbyte;
        `UOTG_OFS_THRESH: thresh_q <= wbyte;
        `UOTG_OFS_CFG1:   cfg1_q   <= wbyte & `UOTG_CFG1_MASK;
        `UOTG_OFS_CFG2:   cfg2_q   <= wbyte & `UOTG_CFG2_MASK;
        `UOTG_OFS_POWER:  power_q  <= wbyte & `UOTG_POWER_MASK;
        default:          ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  // Power gates tokens, frames, eye test and drive monitor; idle halts only when asked
  assign module_run = power_q[`UOTG_BIT_POWER] &&
                      !(cfg1_q[`UOTG_BIT_IDLE_HALT] && sys_idle);
  assign low_speed_mode = addr_q[`UOTG_BIT_LOW_SPEED] && host_mode;

  // ---------------------------------------------------------------
  // Frame timer and token window
  // ---------------------------------------------------------------
  logic [16:0] frame_cnt_q;
  logic [17:0] thr_cycles;   // Full low-speed threshold overflows 17 bits
  logic [16:0] byte_cyc;
  logic        frame_on;
  logic        frame_q;

  assign frame_on   = module_run && host_mode && power_q[`UOTG_BIT_FRAME_EN];
  assign byte_cyc   = low_speed_mode ? 17'(`UOTG_LS_BYTE_CYC) : 17'(`UOTG_FS_BYTE_CYC);
  // Threshold already counts the ten-byte overhead, scaled to cycles
  assign thr_cycles = {10'h000, thresh_q} * {1'b0, byte_cyc};
  // No new token may start inside the last threshold before a marker
  assign window_ok  = !frame_on || ({1'b0, frame_cnt_q} > thr_cycles);
  assign frame_marker = frame_q;

  // Down counter; marker pulse when it wraps
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      frame_cnt_q <= 17'h0_0000;
      frame_q     <= 1'b0;
    end
    else if (!frame_on)
    begin
      frame_cnt_q <= 17'(FRAME_CYCLES - 1);
      frame_q     <= 1'b0;
    end
    else
    begin
      frame_q     <= (frame_cnt_q == 17'h0_0000);
      frame_cnt_q <= (frame_cnt_q == 17'h0_0000) ? 17'(FRAME_CYCLES - 1) : frame_cnt_q - 17'h0_0001;
    end
  end

  // ---------------------------------------------------------------
  // Token launch
  // ---------------------------------------------------------------
  logic       start_q;
  logic [3:0] kind_q;
  logic [3:0] endp_q;
  logic [6:0] dev_q;

  assign token_start     = start_q;
  assign token_kind      = kind_q;
  assign target_endpoint = endp_q;
  assign token_device    = dev_q;

  // Writes while a token is pending or busy do not relaunch
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      state_q <= UOTG_IDLE;
    else
    begin
      unique case (state_q)
        UOTG_IDLE: if (tok_write && host_mode && module_run) state_q <= UOTG_WAIT;
        UOTG_WAIT: if (!module_run) state_q <= UOTG_IDLE;
                   else if (window_ok) state_q <= UOTG_BUSY;
        UOTG_BUSY: if (token_done || !module_run) state_q <= UOTG_IDLE;
        default:   state_q <= UOTG_IDLE;
      endcase
    end
  end

  // Launch pulse carries the kind, endpoint and device number
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      start_q <= 1'b0;
      kind_q  <= 4'h0;
      endp_q  <= 4'h0;
      dev_q   <= 7'h00;
    end
    else
    begin
      start_q <= (state_q == UOTG_WAIT) && module_run && window_ok;
      if ((state_q == UOTG_WAIT) && module_run && window_ok)
      begin
        kind_q <= token_q[7:4];
        endp_q <= token_q[3:0];
        dev_q  <= addr_q[6:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration outputs
  // ---------------------------------------------------------------
  // Drive monitor only reaches the pin with the transceiver bypassed
  assign drive_oe_n = !(cfg1_q[`UOTG_BIT_MONITOR] && cfg2_q[`UOTG_BIT_XCVR_DIS] &&
                        module_run && line_drive);
  assign eye_test_enable             = cfg1_q[`UOTG_BIT_EYE] && module_run;
  assign bus_power_pullup_enable     = cfg2_q[`UOTG_BIT_PULLUP];
  assign external_serial_ctrl_select = cfg2_q[`UOTG_BIT_EXT_SERIAL];
  assign boost_builder_enable        = !cfg2_q[`UOTG_BIT_BOOST_DIS];
  assign digital_vbus_ctrl_enable    = cfg2_q[`UOTG_BIT_BOOST_DIS];
  assign bus_comparator_enable       = !cfg2_q[`UOTG_BIT_CMP_DIS];
  assign digital_vbus_status_enable  = cfg2_q[`UOTG_BIT_CMP_DIS];
  assign transceiver_enable          = !cfg2_q[`UOTG_BIT_XCVR_DIS];
  assign external_xcvr_enable        = cfg2_q[`UOTG_BIT_XCVR_DIS];

  // Per-endpoint even/odd buffering masks
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_pp
      assign pp_out_mask[gi] = uotg_pp_on(cfg1_q[1:0], gi, 1'b1);
      assign pp_in_mask[gi]  = uotg_pp_on(cfg1_q[1:0], gi, 1'b0);
    end
  endgenerate

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n_q);

  sequence s_tok_req;
    tok_write && host_mode && module_run && state_q == UOTG_IDLE;
  endsequence
  sequence s_launch_cond;
    state_q == UOTG_WAIT && window_ok && module_run;
  endsequence

  property p_low_speed;
    low_speed_mode |-> host_mode && addr_q[7];
  endproperty
  a_low_speed: assert property (p_low_speed) else $error("low speed outside host mode");

  property p_upper_zero;
    wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper byte not zero");

  property p_tok_launch;
    s_tok_req |=> state_q == UOTG_WAIT;
  endproperty
  a_tok_launch: assert property (p_tok_launch) else $error("token not launched");

  // A closed window may hold the token back; an open one may not
  property p_launch;
    s_launch_cond |=> token_start && state_q == UOTG_BUSY;
  endproperty
  a_launch: assert property (p_launch) else $error("open window but no launch");

  property p_window;
    token_start |-> $past(window_ok) && $past(state_q) == UOTG_WAIT;
  endproperty
  a_window: assert property (p_window) else $error("token started in closed window");

  property p_tok_fields;
    token_start |-> token_kind == $past(token_q[7:4]) && token_device == $past(addr_q[6:0]);
  endproperty
  a_tok_fields: assert property (p_tok_fields) else $error("token fields wrong");

  property p_oe_mon;
    !drive_oe_n |-> line_drive && cfg1_q[6] && cfg2_q[0];
  endproperty
  a_oe_mon: assert property (p_oe_mon) else $error("drive enable without monitor");

  property p_halt;
    !module_run |=> !token_start && !frame_marker;
  endproperty
  a_halt: assert property (p_halt) else $error("activity while halted");

  property p_frame_gap;
    frame_marker |=> !frame_marker [*8];
  endproperty
  a_frame_gap: assert property (p_frame_gap) else $error("frame markers too close");

  property p_pp;
    (cfg1_q[1:0] == 2'b11) |-> !pp_in_mask[0] && pp_in_mask[15] && !pp_out_mask[0];
  endproperty
  a_pp: assert property (p_pp) else $error("ping-pong decode wrong");

  property p_xcvr;
    $rose(cfg2_q[0]) |-> external_xcvr_enable && !transceiver_enable;
  endproperty
  a_xcvr: assert property (p_xcvr) else $error("transceiver bypass ignored");

  property p_dev_addr;
    wr_en && wb_adr_i == `UOTG_OFS_ADDR && !host_mode |=> !addr_q[`UOTG_BIT_LOW_SPEED];
  endproperty
  a_dev_addr: assert property (p_dev_addr) else $error("low speed kept in device mode");

  property p_cfg_mask;
    wb_ack_o && !wb_we_i && wb_adr_i == `UOTG_OFS_CFG1 |-> wb_dat_o[5] == 1'b0 && wb_dat_o[3:2] == 2'b00;
  endproperty
  a_cfg_mask: assert property (p_cfg_mask) else $error("unused config bits read back");

endmodule : uotg_cfg
`default_nettype wire

// ---- inc/uotg_params.svh ----
// Overview of operation
// - Low-speed bit selects low or full speed
// - Low-speed bit exists only in host mode
// - Seven-bit device number, read and write
// - Token kinds: SETUP 1101, IN 1001, OUT 0001
// - Threshold is ten plus largest packet bytes
// - Eye-test bit starts the eye pattern
// - Monitor bit gives active-low drive enable
// - Drive monitor only while transceiver bypassed
// - Idle-halt bit stops the block in idle
// - Ping-pong field selects even/odd buffering
// - Pull-up bit switches the bus power pull-up
// - Select bit picks serial or dedicated control
// - Boost builder off, digital output control on
// - Comparator off, digital status input on
// - Transceiver off, external transceiver interface on
// - Upper byte reads zero, ignores writes
// - Power enable turns on tokens, frames, eye test and drive monitor
// - Frame marker every millisecond in host mode
`ifndef UOTG_PARAMS_SVH
`define UOTG_PARAMS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define UOTG_OFS_ADDR   8'h00
`define UOTG_OFS_TOKEN  8'h04
`define UOTG_OFS_THRESH 8'h08
`define UOTG_OFS_CFG1   8'h0c
`define UOTG_OFS_CFG2   8'h10
`define UOTG_OFS_POWER  8'h14
`define UOTG_OFS_STATUS 8'h18

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define UOTG_BIT_LOW_SPEED  7
`define UOTG_BIT_EYE        7
`define UOTG_BIT_MONITOR    6
`define UOTG_BIT_IDLE_HALT  4
`define UOTG_BIT_PULLUP     4
`define UOTG_BIT_EXT_SERIAL 3
`define UOTG_BIT_BOOST_DIS  2
`define UOTG_BIT_CMP_DIS    1
`define UOTG_BIT_XCVR_DIS   0
`define UOTG_BIT_POWER      0
`define UOTG_BIT_HOST       1
`define UOTG_BIT_FRAME_EN   2
`define UOTG_CFG1_MASK      8'hd3
`define UOTG_CFG2_MASK      8'h1f
`define UOTG_POWER_MASK     8'h07
`define UOTG_RESET_BYTE     8'h00
`define UOTG_THRESH_OVERHEAD 10

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define UOTG_CLK_MHZ      100
`define UOTG_FRAME_US     1000
`define UOTG_FRAME_CYCLES (`UOTG_FRAME_US * `UOTG_CLK_MHZ)
`define UOTG_FS_BYTE_NS   667
`define UOTG_LS_BYTE_NS   5333
`define UOTG_FS_BYTE_CYC  ((`UOTG_FS_BYTE_NS * `UOTG_CLK_MHZ) / 1000)
`define UOTG_LS_BYTE_CYC  ((`UOTG_LS_BYTE_NS * `UOTG_CLK_MHZ) / 1000)

`endif

// ---- inc/uotg_pkg.sv ----
`default_nettype none
package uotg_pkg;
  // Token launch sequencer, one bit per step except BUSY to IDLE
  typedef enum logic [1:0] {
    UOTG_IDLE = 2'b00,
    UOTG_WAIT = 2'b01,
    UOTG_BUSY = 2'b11
  } uotg_tok_state_type;

  // Token kinds
  typedef enum logic [3:0] {
    UOTG_TOK_OUT   = 4'h1,
    UOTG_TOK_IN    = 4'h9,
    UOTG_TOK_SETUP = 4'hd
  } uotg_tok_kind_type;
endpackage : uotg_pkg
`default_nettype wire

// ---- verification/uotg_engine_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Serial engine stand-in: runs each launched token for a while
// ---------------------------------------------------------------
module uotg_engine_model
#(
  parameter int DONE_DELAY = 6
)(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // Token link
  input  wire logic token_start,
  output logic      token_done,
  output logic      line_drive,
  // Launch count for the bench
  output int        starts
);
  int cnt_q;

  // Lines driven only while a token runs, so the monitor has a real window
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q      <= 0;
      starts     <= 0;
      token_done <= 1'b0;
      line_drive <= 1'b0;
    end
    else
    begin
      token_done <= 1'b0;
      if (token_start)
      begin
        starts     <= starts + 1;
        cnt_q      <= DONE_DELAY;
        line_drive <= 1'b1;
      end
      else if (cnt_q == 1)
      begin
        cnt_q      <= 0;
        token_done <= 1'b1;
        line_drive <= 1'b0;
      end
      else if (cnt_q > 1)
        cnt_q <= cnt_q - 1;
    end
  end
endmodule : uotg_engine_model
`default_nettype wire

// ---- verification/usb_otg_addr_token_config_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module usb_otg_addr_token_config_tb_top
  import uotg_pkg::*;
;
  // Short frame keeps the run brief; window opens above 66 cycles
  localparam int FR = 200;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        idle = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic        ack, tstart, fmark, ls, run, eye, oe_n, pull, ser, bst, dctl, cmp, dst, xcv, xext;
  logic        ldrv, tdone, seen;
  logic [3:0]  tkind, tep;
  logic [6:0]  tdev;
  logic [15:0] ppo, ppi;
  logic [4:0]  b;
  int          starts, n;
  int          err_total = 0;
  int          total_checks = 0;
  int          cycles = 0;
  uotg_tok_kind_type kinds [3] = '{UOTG_TOK_SETUP, UOTG_TOK_IN, UOTG_TOK_OUT};

  always #5 mclk = ~mclk;

  uotg_cfg #(.FRAME_CYCLES(FR)) uotg_cfg_i (
    .mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .line_drive(ldrv),
    .token_done(tdone), .sys_idle(idle), .token_start(tstart), .token_kind(tkind),
    .target_endpoint(tep), .token_device(tdev), .frame_marker(fmark), .low_speed_mode(ls),
    .module_run(run), .eye_test_enable(eye), .drive_oe_n(oe_n), .pp_out_mask(ppo), .pp_in_mask(ppi),
    .bus_power_pullup_enable(pull), .external_serial_ctrl_select(ser), .boost_builder_enable(bst),
    .digital_vbus_ctrl_enable(dctl), .bus_comparator_enable(cmp), .digital_vbus_status_enable(dst),
    .transceiver_enable(xcv), .external_xcvr_enable(xext));

  uotg_engine_model uotg_engine_model_i (
    .mclk(mclk), .rstn(rstn), .token_start(tstart), .token_done(tdone), .line_drive(ldrv),
    .starts(starts));

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Classic cycle: hold everything until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do @(posedge mclk); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask : rd

  // Let register updates reach the level outputs
  task automatic st();
    @(posedge mclk);
  endtask : st

  task automatic wait_start(input int lim);
    seen = 1'b0;
    repeat (lim)
    begin
      @(posedge mclk);
      if (tstart === 1'b1)
      begin
        seen = 1'b1;
        break;
      end
    end
  endtask : wait_start

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // Hang guard, well above the expected run length
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      results();
    end
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 5; i++) rd("reset value", 8'(i * 4), 32'h0);
    chk("reset part enables", {bst, cmp, xcv, oe_n}, 4'hf);
    wr(8'h00, 32'hffff_ffff);
    rd("addr device mode", 8'h00, 32'h7f);
    wr(8'h14, 32'h3);
    wr(8'h00, 32'hffff_ff85);
    rd("addr host mode", 8'h00, 32'h85);
    st();
    chk("low speed", ls, 1'b1);
    wr(8'h00, 32'h05);
    st();
    chk("full speed", ls, 1'b0);
    wr(8'h0c, 32'hffff_ffff);
    rd("cfg1 mask", 8'h0c, 32'hd3);
    st();
    chk("eye test", eye, 1'b1);
    idle <= 1'b1;
    st();
    chk("halted in idle", {run, eye}, 2'b00);
    wr(8'h0c, 32'h80);
    st();
    chk("runs in idle", {run, eye}, 2'b11);
    idle <= 1'b0;
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h0c, 32'(c));
      st();
      chk("pingpong", {ppo, ppi}, c == 3 ? 32'hfffe_fffe : c == 2 ? 32'hffff_ffff : c == 1 ? 32'h0001_0000 : 0);
    end
    wr(8'h14, 32'h2);
    for (int i = 0; i < 5; i++)
    begin
      b = 5'(1 << i);
      wr(8'h10, 32'(b));
      rd("cfg2", 8'h10, 32'(b));
      chk("cfg2 outputs", {pull, ser, bst, dctl, cmp, dst, xcv, xext}, {b[4], b[3], ~b[2], b[2], ~b[1], b[1], ~b[0], b[0]});
    end
    wr(8'h10, 32'hff);
    rd("cfg2 mask", 8'h10, 32'h1f);
    // Host with frames; closed window first, then each token kind
    wr(8'h14, 32'h7);
    wr(8'h0c, 32'h40);
    wr(8'h08, 32'hff);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h14, 32'h6);
      wr(8'h10, 32'(i % 2));
      wr(8'h14, 32'h7);
      wr(8'h04, {24'h0, kinds[i], 4'(i + 2)});
      if (i == 0)
      begin
        wait_start(450);
        chk("launch with closed window", seen, 1'b0);
        wr(8'h08, 32'h1);
      end
      wait_start(450);
      chk("launch", seen, 1'b1);
      chk("token fields", {tkind, tep, tdev}, {kinds[i], 4'(i + 2), 7'h05});
      st();
      st();
      chk("drive monitor", oe_n, (i % 2) ? 1'b0 : 1'b1);
      repeat (12) @(posedge mclk);
    end
    n = 0;
    do begin @(posedge mclk); n++; end while (fmark !== 1'b1 && n < 300);
    n = 0;
    do begin @(posedge mclk); n++; end while (fmark !== 1'b1 && n < 300);
    chk("frame spacing", n, FR);
    wr(8'h14, 32'h5);
    wr(8'h04, {24'h0, UOTG_TOK_IN, 4'h1});
    wait_start(300);
    chk("no launch in device mode", seen, 1'b0);
    chk("engine launches", starts, 3);
    rd("unmapped", 8'h1c, 32'h0);
    wr(8'h14, 32'h0);
    st();
    chk("power off", {run, eye}, 2'b00);
    results();
  end
endmodule : usb_otg_addr_token_config_tb_top
`default_nettype wire
